// *** hdl/rps_pkg.sv ***
// Constants shared by the rail power-up sequencer and its monitor filter.
// Assumes a 20 MHz system clock; all delays are derived from it.
package rps_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  // System clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Request to core enable delay, in milliseconds.
  localparam int unsigned EN_DLY_MS = 11;
  // Enable to monitor test delay, in milliseconds.
  localparam int unsigned MON_DLY_MS = 10;
  // Last test pass to reset release delay, in milliseconds.
  localparam int unsigned RST_DLY_MS = 10;
  // Longest undervoltage excursion that must be ignored, in microseconds.
  localparam int unsigned GLITCH_MIN_US = 20;
  // Longest excursion that may still be ignored, in microseconds.
  localparam int unsigned GLITCH_MAX_US = 1000;

  // Cycle counts, rounded down for typical delays.
  localparam int unsigned EN_DLY_CYC = EN_DLY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned MON_DLY_CYC = MON_DLY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RST_DLY_CYC = RST_DLY_MS * 1000000 / CLK_PERIOD_NS;
  // Filter window: a least time, so it rounds up.
  localparam int unsigned GLITCH_CYC =
      (GLITCH_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the sequencing timer.
  localparam int unsigned TMR_W = 20;
  // Width of the glitch filter counter.
  localparam int unsigned FLT_W = 12;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [6:0] {
    RPS_OFF = 7'b000_0001, // Idle, request low.
    RPS_WAIT_EN = 7'b000_0010, // Waiting to raise core enable.
    RPS_CORE = 7'b000_0100, // Core on, waiting for its test.
    RPS_MID = 7'b000_1000, // Mid on, waiting for its test.
    RPS_IO = 7'b001_0000, // I/O on, waiting for its test.
    RPS_REL = 7'b010_0000, // Tests passed, waiting to release.
    RPS_DONE = 7'b100_0000 // Released, or halted after a failure.
  } rps_state_t;

endpackage

// *** hdl/rps_flt_if.sv ***
// Interface carrying one supply monitor level into its glitch filter.
// Assumes the raw level is already synchronised to the system clock.
interface rps_flt_if;
  // Synchronised raw good level from the comparator.
  logic raw_good;
  // Filtered good level.
  logic good;
  modport filt (input raw_good, output good);
  modport user (output raw_good, input good);
endinterface

// *** hdl/rps_glitch_filter.sv ***
// Glitch filter for one supply monitor good level.
// Assumes a synchronised input; the filter itself adds no crossing.
module rps_glitch_filter (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  rps_flt_if.filt flt
);

  // ==========================================================================
  // Filter counter
  // ==========================================================================
  // Counts how long the raw level has disagreed with the filtered level.
  logic [rps_pkg::FLT_W-1:0] cnt_q;
  // Filtered level; starts at "not good" so nothing passes before proof.
  logic good_q;

  // A change is only accepted after it has held for the full window.
  // The window sits at the short end of the allowed range so real faults
  // are still caught quickly.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      good_q <= 1'b0;
    end else if (flt.raw_good == good_q) begin
      cnt_q <= '0;
    end else if (cnt_q ==
                 rps_pkg::FLT_W'(rps_pkg::GLITCH_CYC - 1)) begin
      cnt_q <= '0;
      good_q <= flt.raw_good;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign flt.good = good_q;

endmodule

// *** hdl/rps_sequencer.sv ***
// Rail power-up sequencer: timed rail enables, monitor tests and reset.
// Assumes asynchronous pin inputs and a 20 MHz internal clock.

// Functional notes
// - Core enable 11 ms after request rise.
// - Core test fixed 10 ms after enable.
// - Mid test fixed 10 ms after enable.
// - I/O test fixed 10 ms after enable.
// - Enables spaced 10 ms, core-mid-I/O.
// - Reset released 10 ms after I/O pass.
// - Release delay starts at I/O pass.
// - Failed test holds reset, halts sequence.
// - Monitors ignore short undervoltage glitches.
module rps_sequencer (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic projector_power_request_in,
  input wire logic core_good_in,
  input wire logic mid_good_in,
  input wire logic io_good_in,
  output logic core_rail_enable_out,
  output logic mid_rail_enable_out,
  output logic io_rail_enable_out,
  output logic system_reset_n_out,
  output logic seq_fail_out
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Two stages for the request and three monitor levels.
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  // First stage is read only by the second stage.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {projector_power_request_in, io_good_in, mid_good_in,
                  core_good_in};
      sync2_q <= sync1_q;
    end
  end

  // Synchronised request level.
  logic req;
  assign req = sync2_q[3];

  // ==========================================================================
  // Monitor glitch filters
  // ==========================================================================
  // One filter per rail; the filtered levels are what each test samples.
  rps_flt_if flt_if[3] ();
  logic [2:0] good;

  for (genvar g = 0; g < 3; g++) begin : g_flt
    assign flt_if[g].raw_good = sync2_q[g];
    assign good[g] = flt_if[g].good;
    rps_glitch_filter rps_glitch_filter_inst (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .flt(flt_if[g])
    );
  end

  // ==========================================================================
  // Request edge detect
  // ==========================================================================
  // Previous request level, for the rising edge.
  logic req_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req;
    end
  end

  // Rising edge of the request; a new edge is the only way to restart.
  logic req_rise;
  assign req_rise = req && !req_q;

  // ==========================================================================
  // Sequencer state and timer
  // ==========================================================================
  rps_pkg::rps_state_t state_q;
  rps_pkg::rps_state_t state_d;
  // Down-counter for the current stage.
  logic [rps_pkg::TMR_W-1:0] tmr_q;
  logic [rps_pkg::TMR_W-1:0] tmr_d;
  // Timer has run out.
  logic tmr_done;
  assign tmr_done = (tmr_q == '0);

  // Next state; the timer reloads on every change into a timed stage.
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_done ? tmr_q : tmr_q - 1'b1;
    if (!req) begin
      // Dropping the request is the power-down path.
      state_d = rps_pkg::RPS_OFF;
      tmr_d = '0;
    end else begin
      unique case (state_q)
        rps_pkg::RPS_OFF: begin
          if (req_rise) begin
            state_d = rps_pkg::RPS_WAIT_EN;
            tmr_d = rps_pkg::TMR_W'(rps_pkg::EN_DLY_CYC - 1);
          end
        end
        rps_pkg::RPS_WAIT_EN: begin
          if (tmr_done) begin
            state_d = rps_pkg::RPS_CORE;
            tmr_d = rps_pkg::TMR_W'(rps_pkg::MON_DLY_CYC - 1);
          end
        end
        rps_pkg::RPS_CORE: begin
          // Full wait even if the rail came up early.
          if (tmr_done) begin
            if (good[0]) begin
              state_d = rps_pkg::RPS_MID;
              tmr_d = rps_pkg::TMR_W'(rps_pkg::MON_DLY_CYC - 1);
            end else begin
              state_d = rps_pkg::RPS_DONE;
            end
          end
        end
        rps_pkg::RPS_MID: begin
          if (tmr_done) begin
            if (good[1]) begin
              state_d = rps_pkg::RPS_IO;
              tmr_d = rps_pkg::TMR_W'(rps_pkg::MON_DLY_CYC - 1);
            end else begin
              state_d = rps_pkg::RPS_DONE;
            end
          end
        end
        rps_pkg::RPS_IO: begin
          if (tmr_done) begin
            if (good[2]) begin
              // Release delay counts from the pass, not the threshold.
              state_d = rps_pkg::RPS_REL;
              tmr_d = rps_pkg::TMR_W'(rps_pkg::RST_DLY_CYC - 1);
            end else begin
              state_d = rps_pkg::RPS_DONE;
            end
          end
        end
        rps_pkg::RPS_REL: begin
          if (tmr_done) begin
            state_d = rps_pkg::RPS_DONE;
          end
        end
        rps_pkg::RPS_DONE: begin
          state_d = rps_pkg::RPS_DONE;
        end
        default: begin
          state_d = rps_pkg::RPS_OFF;
        end
      endcase
    end
  end

  // State and timer registers.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= rps_pkg::RPS_OFF;
      tmr_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Released flag and failure flag, both held until the request drops.
  logic released_q;
  logic fail_q;

  // Enables and reset come straight from flops, decoded from the next state
  // so each pin moves on the same edge as the state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_rail_enable_out <= 1'b0;
      mid_rail_enable_out <= 1'b0;
      io_rail_enable_out <= 1'b0;
      system_reset_n_out <= 1'b0;
      released_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (state_d == rps_pkg::RPS_OFF) begin
      // Request low: everything off and reset held.
      core_rail_enable_out <= 1'b0;
      mid_rail_enable_out <= 1'b0;
      io_rail_enable_out <= 1'b0;
      system_reset_n_out <= 1'b0;
      released_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (state_d == rps_pkg::RPS_CORE) begin
        core_rail_enable_out <= 1'b1;
      end
      if (state_d == rps_pkg::RPS_MID) begin
        mid_rail_enable_out <= 1'b1;
      end
      if (state_d == rps_pkg::RPS_IO) begin
        io_rail_enable_out <= 1'b1;
      end
      if (state_q == rps_pkg::RPS_REL && tmr_done) begin
        released_q <= 1'b1;
        system_reset_n_out <= 1'b1;
      end
      if (state_d == rps_pkg::RPS_DONE && !released_q &&
          state_q != rps_pkg::RPS_REL) begin
        // Enables are left as they were; the host must restart.
        fail_q <= 1'b1;
      end
    end
  end

  assign seq_fail_out = fail_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_core_on;
    $rose(core_rail_enable_out);
  endsequence

  property p_core_delay;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(core_rail_enable_out) |-> $past(state_q) == rps_pkg::RPS_WAIT_EN;
  endproperty
  a_core_delay: assert property (p_core_delay)
    else $error("Core enable rose outside its delay stage.");

  property p_mid_after_core;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(mid_rail_enable_out) |-> core_rail_enable_out && good[0];
  endproperty
  a_mid_after_core: assert property (p_mid_after_core)
    else $error("Mid enable rose without a core pass.");

  property p_io_after_mid;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(io_rail_enable_out) |-> mid_rail_enable_out && good[1];
  endproperty
  a_io_after_mid: assert property (p_io_after_mid)
    else $error("I/O enable rose without a mid pass.");

  property p_rel_after_io;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(system_reset_n_out) |-> io_rail_enable_out &&
        $past(state_q) == rps_pkg::RPS_REL;
  endproperty
  a_rel_after_io: assert property (p_rel_after_io)
    else $error("Reset released outside the release stage.");

  property p_rel_start;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    state_q == rps_pkg::RPS_IO && tmr_done && good[2] && req
        |=> state_q == rps_pkg::RPS_REL && !system_reset_n_out;
  endproperty
  a_rel_start: assert property (p_rel_start)
    else $error("I/O pass did not start the release delay.");

  property p_fail_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    fail_q |-> !system_reset_n_out;
  endproperty
  a_fail_hold: assert property (p_fail_hold)
    else $error("Reset released after a failed test.");

  property p_off_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !req |=> !core_rail_enable_out && !mid_rail_enable_out &&
        !io_rail_enable_out && !system_reset_n_out;
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("Outputs active while the request is low.");

  // Consecutive cycles for which the synchronised I/O monitor level has been
  // low, saturating. It is kept apart from the filter's own counter so that
  // the check below does not simply restate the filter.
  logic [rps_pkg::FLT_W-1:0] io_low_run_q;

  // Restarts on every high sample of the raw level.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_low_run_q <= '0;
    end else if (sync2_q[2]) begin
      io_low_run_q <= '0;
    end else if (io_low_run_q != '1) begin
      io_low_run_q <= io_low_run_q + 1'b1;
    end
  end

  // The filtered level may only fall once the dip has lasted the window.
  property p_glitch;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(good[2]) |->
        io_low_run_q >= rps_pkg::FLT_W'(rps_pkg::GLITCH_CYC);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("I/O filter dropped on a dip shorter than its window.");

  property p_core_first;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_core_on |-> !mid_rail_enable_out && !io_rail_enable_out;
  endproperty
  a_core_first: assert property (p_core_first)
    else $error("Core enable was not the first to rise.");

endmodule

// *** verification/rps_rail_model.sv ***
// Model of the external regulators and their supply comparators.
// Assumes controls change just after a clock edge.
module rps_rail_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [2:0] en_in,
  input wire logic [2:0] pre_on_in,
  input wire logic [2:0] fail_in,
  input wire logic [2:0] glitch_in,
  input wire logic [19:0] ramp_cyc_in,
  output logic [2:0] good_out
);
  // ==========================================================
  // Ramp timers
  // ==========================================================
  // Cycles for which each rail has been enabled.
  logic [19:0] ramp_q [3];

  // A rail ramps while enabled and collapses at once when disabled.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_q <= '{default: 20'h0_0000};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!en_in[i]) begin
          ramp_q[i] <= 20'h0_0000;
        end else if (ramp_q[i] != 20'hf_ffff) begin
          ramp_q[i] <= ramp_q[i] + 20'h0_0001;
        end
      end
    end
  end

  // ==========================================================
  // Comparator levels
  // ==========================================================
  // A rail may be up before its enable, as a shared supply can be.
  // Fail and glitch are set only when a bench scenario asks.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      good_out[i] = (pre_on_in[i] | (en_in[i] & (ramp_q[i] >= ramp_cyc_in)))
          & ~fail_in[i] & ~glitch_in[i];
    end
  end
endmodule

// *** verification/rail_powerup_sequencer_tb_top.sv ***
// Self-checking bench for the rail power-up sequencer.
// Assumes the regulator model sits on the rail side of the design.
module rail_powerup_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int EN = rps_pkg::EN_DLY_CYC;
  localparam int MON = rps_pkg::MON_DLY_CYC;
  localparam int RST = rps_pkg::RST_DLY_CYC;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [2:0] pre_on = 3'h0;
  logic [2:0] fail = 3'h0;
  logic [2:0] glitch = 3'h0;
  logic [19:0] ramp = 20'h0_0001;
  logic [2:0] en;
  logic [2:0] good;
  logic rst_out_n;
  logic seq_fail;
  logic [4:0] outs;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  assign outs = {seq_fail, rst_out_n, en};

  // The 20 MHz clock and a cycle count used to time every edge.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  rps_sequencer rps_sequencer_inst (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n),
    .projector_power_request_in(req),
    .core_good_in(good[0]), .mid_good_in(good[1]), .io_good_in(good[2]),
    .core_rail_enable_out(en[0]), .mid_rail_enable_out(en[1]),
    .io_rail_enable_out(en[2]), .system_reset_n_out(rst_out_n),
    .seq_fail_out(seq_fail));
  rps_rail_model rps_rail_model_inst (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .en_in(en),
    .pre_on_in(pre_on), .fail_in(fail), .glitch_in(glitch),
    .ramp_cyc_in(ramp), .good_out(good));

  // ==========================================================
  // Checking tasks
  // ==========================================================
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d failed", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // True when a delay seen at the pins fits the synchroniser slack.
  function automatic logic in_win(input int d, input int e);
    return d >= e + 1 && d <= e + 6;
  endfunction

  // Waits a bounded time for output bit idx to reach val.
  // A missing edge is an error only when must is set; t is -1 then.
  task automatic wait_bit(input int idx, input logic val, input int bound,
      input logic must, output int t);
    t = -1;
    for (int i = 0; i < bound && t < 0; i++) begin
      @(posedge clk_sys);
      #1;
      if (outs[idx] === val) t = cyc;
    end
    if (t < 0 && must) begin
      fail_count++;
      $display("[FAIL] wait on output %0d expected %0b seen none", idx, val);
      give_verdict();
    end
  endtask

  // Raises the request at an edge and returns that edge's count.
  task automatic raise_req(output int t);
    @(posedge clk_sys);
    req <= 1'b1;
    #1 t = cyc;
  endtask

  // Drops the request and checks that everything turns off.
  task automatic drop_req();
    int t;
    @(posedge clk_sys);
    req <= 1'b0;
    wait_bit(0, 1'b0, 10, 1'b1, t);
    repeat (2) @(posedge clk_sys);
    #1 check("outputs after request low", 32'(outs), 32'h0);
    repeat (4) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    int t0, t1, t2, t3, t4, k;
    void'($urandom(32'h81de));
    repeat (15) @(posedge clk_sys);
    #1 check("outputs in reset", 32'(outs), 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);

    // Pass run: random ramps, some rails up early, short I/O dip.
    pre_on <= 3'($urandom_range(0, 7));
    ramp <= 20'($urandom_range(1, 150000));
    raise_req(t0);
    wait_bit(0, 1'b1, EN + 10, 1'b1, t1);
    check("core enable delay", 32'(in_win(t1 - t0, EN)), 32'h1);
    wait_bit(1, 1'b1, MON + 10, 1'b1, t2);
    check("mid enable spacing", 32'(t2 - t1), 32'(MON));
    wait_bit(2, 1'b1, MON + 10, 1'b1, t3);
    check("io enable spacing", 32'(t3 - t2), 32'(MON));
    // The dip is 15 us, under the filter window, and straddles the I/O
    // test edge, so an unfiltered monitor would fail the test.
    repeat (MON - 150) @(posedge clk_sys);
    glitch <= 3'h4;
    repeat (300) @(posedge clk_sys);
    glitch <= 3'h0;
    wait_bit(3, 1'b1, MON + RST, 1'b1, t4);
    check("reset release", 32'(t4 - t3), 32'(MON + RST));
    check("no failure flagged", 32'(seq_fail), 32'h0);
    $display("Test pass run done");
    drop_req();

    // Failing run: one random rail never comes good.
    k = $urandom_range(0, 2);
    pre_on <= 3'h0;
    fail <= 3'h1 << k;
    ramp <= 20'($urandom_range(1, 150000));
    raise_req(t0);
    wait_bit(0, 1'b1, EN + 10, 1'b1, t1);
    wait_bit(4, 1'b1, MON * (k + 1) + 10, 1'b1, t2);
    check("failure time", 32'(t2 - t1), 32'(MON * (k + 1)));
    wait_bit(3, 1'b1, RST + 1000, 1'b0, t3);
    check("reset held after failure", 32'(t3 < 0), 32'h1);
    if (k < 2) begin
      check("sequence halted", 32'(outs[k + 1]), 32'h0);
    end
    $display("Test failing rail %0d done", k);

    // Restart: a full off then on must begin the sequence afresh.
    fail <= 3'h0;
    drop_req();
    raise_req(t0);
    wait_bit(0, 1'b1, EN + 10, 1'b1, t1);
    check("restart core delay", 32'(in_win(t1 - t0, EN)), 32'h1);
    check("failure flag cleared", 32'(seq_fail), 32'h0);
    $display("Test restart done");
    give_verdict();
  end
endmodule
